// ==== src/pmi_i2c_regs.sv ====
// Two-wire target with the byte-wide register map behind it
`timescale 1ns/100ps
module pmi_i2c_regs (
    // Clock and reset
    input  wire logic   sys_clk,
    input  wire logic   resetn,
    input  wire logic   soft_rst,
    // Serial bus pins
    input  wire logic   scl_i,
    input  wire logic   sda_i,
    output logic        sda_o,
    output logic        sda_oe,
    // Address strap
    input  wire logic   otp_addr_sel,
    // Register contents for the block's consumers
    output logic [7:0]  undervoltage_lockout_config,
    output logic [7:0]  power_config
);
    import pmi_pkg::*;
    pmi_sync_if sync ();
    pmi_pin_sync u_sync (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .scl_i        (scl_i),
        .sda_i        (sda_i),
        .otp_addr_sel (otp_addr_sel),
        .sync         (sync)
    );
    pmi_state_t state_q;
    pmi_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       ackph_q;
    logic       ackph_d;
    logic       rd_q;
    logic       rd_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic       sda_oe_q;
    logic       sda_oe_d;
    logic       sda_o_q;
    logic       scl_p_q;
    logic       scl_p_d;
    logic       sda_p_q;
    logic       sda_p_d;
    logic       wr_en;
    logic [7:0] mem_q [PMI_REGS];
    logic [7:0] mem_d [PMI_REGS];
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;
    logic [6:0] own_addr;
    logic [7:0] rd_byte;
    // Edges and conditions from the synchronised lines only
    assign scl_rise = sync.scl_s && !scl_p_q;              // RULE_23
    assign scl_fall = !sync.scl_s && scl_p_q;
    // SDA moving while SCL stays high is START or STOP
    assign start_ev = sync.scl_s && scl_p_q && sda_p_q && !sync.sda_s; // RULE_06
    assign stop_ev  = sync.scl_s && scl_p_q && !sda_p_q && sync.sda_s; // RULE_06
    assign own_addr = {PMI_ADDR_HI, sync.sel_s};           // RULE_20
    assign rd_byte  = pmi_valid(ptr_q) ? mem_q[ptr_q[4:0]] : PMI_READ_NONE;
    always_comb
    begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        ackph_d  = ackph_q;
        rd_d     = rd_q;
        shift_d  = shift_q;
        tx_d     = tx_q;
        ptr_d    = ptr_q;
        sda_oe_d = sda_oe_q;
        scl_p_d  = sync.scl_s;
        sda_p_d  = sync.sda_s;
        wr_en    = 1'b0;
        if (start_ev)
        begin
            // Plain and repeated START both restart addressing
            state_d  = ST_ADDR;                            // RULE_02
            cnt_d    = 4'h0;
            ackph_d  = 1'b0;
            sda_oe_d = 1'b0;
        end
        else if (stop_ev)
        begin
            state_d  = ST_IDLE;                            // RULE_07
            cnt_d    = 4'h0;
            ackph_d  = 1'b0;
            sda_oe_d = 1'b0;
        end
        else if (scl_rise && state_q != ST_IDLE)
        begin
            if (!ackph_q && cnt_q != PMI_ACK_SLOT)
            begin
                if (state_q != ST_RDATA)
                    shift_d = {shift_q[6:0], sync.sda_s};  // RULE_05
                cnt_d = 4'(cnt_q + 4'h1);
            end
            else if (ackph_q && state_q == ST_RDATA && sync.sda_s)
            begin
                // Host refused the byte: read is over
                state_d  = ST_IDLE;                        // RULE_16
                ackph_d  = 1'b0;
                cnt_d    = 4'h0;
                sda_oe_d = 1'b0;
            end
        end
        else if (scl_fall && state_q == ST_RDATA)
        begin
            if (cnt_q != PMI_ACK_SLOT)
            begin
                tx_d     = {tx_q[6:0], 1'b0};              // RULE_14
                sda_oe_d = !tx_q[6];
            end
            else if (!ackph_q)
            begin
                sda_oe_d = 1'b0;
                ackph_d  = 1'b1;
                ptr_d    = pmi_next_ptr(ptr_q);            // RULE_22
            end
            else
            begin
                // Host acknowledged: next register goes out
                tx_d     = rd_byte;                        // RULE_15
                sda_oe_d = !rd_byte[7];
                cnt_d    = 4'h0;
                ackph_d  = 1'b0;
            end
        end
        else if (scl_fall && cnt_q == PMI_ACK_SLOT && ackph_q)
        begin
            // End of the ninth clock: give the line back
            ackph_d  = 1'b0;
            cnt_d    = 4'h0;
            sda_oe_d = 1'b0;                               // RULE_17
            unique case (state_q)
                ST_ADDR:
                begin
                    if (rd_q)
                    begin
                        state_d  = ST_RDATA;               // RULE_14
                        tx_d     = rd_byte;
                        sda_oe_d = !rd_byte[7];
                    end
                    else
                        state_d = ST_REG;                  // RULE_04
                end
                ST_REG:   state_d = ST_WDATA;
                default:  state_d = state_q;
            endcase
        end
        else if (scl_fall && cnt_q == PMI_ACK_SLOT)
        begin
            unique case (state_q)
                ST_ADDR:
                begin
                    if (shift_q[7:1] == own_addr)
                    begin
                        sda_oe_d = 1'b1;                   // RULE_08
                        ackph_d  = 1'b1;
                        rd_d     = shift_q[0];             // RULE_03
                    end
                    else
                    begin
                        state_d = ST_IDLE;
                        cnt_d   = 4'h0;
                    end
                end
                ST_REG:
                begin
                    if (pmi_valid(shift_q))
                    begin
                        ptr_d    = shift_q;                // RULE_09
                        sda_oe_d = 1'b1;
                        ackph_d  = 1'b1;
                    end
                    else
                    begin
                        // Refusal: line stays released
                        state_d = ST_IDLE;                 // RULE_18
                        cnt_d   = 4'h0;
                    end
                end
                ST_WDATA:
                begin
                    wr_en    = 1'b1;                       // RULE_10
                    sda_oe_d = 1'b1;                       // RULE_12
                    ackph_d  = 1'b1;
                    ptr_d    = pmi_next_ptr(ptr_q);        // RULE_11
                end
                default:
                begin
                    state_d = ST_IDLE;
                    cnt_d   = 4'h0;
                end
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q  <= ST_IDLE;
            cnt_q    <= 4'h0;
            ackph_q  <= 1'b0;
            rd_q     <= 1'b0;
            shift_q  <= 8'h00;
            tx_q     <= 8'h00;
            ptr_q    <= PMI_ZERO_OFS;
            sda_oe_q <= 1'b0;
            sda_o_q  <= 1'b0;
            scl_p_q  <= 1'b1;
            sda_p_q  <= 1'b1;
        end
        else
        begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            ackph_q  <= ackph_d;
            rd_q     <= rd_d;
            shift_q  <= shift_d;
            tx_q     <= tx_d;
            ptr_q    <= ptr_d;
            sda_oe_q <= sda_oe_d;
            sda_o_q  <= 1'b0;
            scl_p_q  <= scl_p_d;
            sda_p_q  <= sda_p_d;
        end
    end

    // Register file; soft reset wins over a write in the same cycle
    always_comb
    begin
        for (int i = 0; i < PMI_REGS; i++)
            mem_d[i] = mem_q[i];
        if (soft_rst)
        begin
            for (int i = 0; i < PMI_REGS; i++)
                mem_d[i] = pmi_reg_default(5'(i));         // RULE_21
        end
        else if (wr_en && pmi_writable(ptr_q))
            mem_d[ptr_q[4:0]] = shift_q;                   // RULE_10
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < PMI_REGS; i++)
                mem_q[i] <= pmi_reg_default(5'(i));        // RULE_21
        end
        else
        begin
            for (int i = 0; i < PMI_REGS; i++)
                mem_q[i] <= mem_d[i];
        end
    end

    assign sda_o                       = sda_o_q;
    assign sda_oe                      = sda_oe_q;
    assign undervoltage_lockout_config = mem_q[PMI_UVLO_OFS[4:0]];
    assign power_config                = mem_q[PMI_PWR_OFS[4:0]];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_wdata_slot;
        scl_fall && state_q == ST_WDATA && cnt_q == PMI_ACK_SLOT && !ackph_q
            && !soft_rst;
    endsequence
    sequence s_rd_enter;
        scl_fall && state_q == ST_ADDR && ackph_q && rd_q && !start_ev;
    endsequence
    property p_idle_release;
        state_q == ST_IDLE |-> !sda_oe_q;
    endproperty
    a_idle_release: assert property (p_idle_release) // RULE_07
        else $error("data line driven while idle");
    property p_stop_idle;
        stop_ev |=> state_q == ST_IDLE && !sda_oe_q;
    endproperty
    a_stop_idle: assert property (p_stop_idle) // RULE_06
        else $error("stop did not return to idle");
    property p_start_addr;
        start_ev |=> state_q == ST_ADDR && cnt_q == 4'h0;
    endproperty
    a_start_addr: assert property (p_start_addr) // RULE_06
        else $error("start did not restart addressing");
    property p_addr_ack;
        scl_fall && state_q == ST_ADDR && cnt_q == PMI_ACK_SLOT && !ackph_q
            && shift_q[7:1] == own_addr |=> sda_oe_q && rd_q == $past(shift_q[0]);
    endproperty
    a_addr_ack: assert property (p_addr_ack) // RULE_08
        else $error("own address not acknowledged");
    property p_reg_nack;
        scl_fall && state_q == ST_REG && cnt_q == PMI_ACK_SLOT && !ackph_q
            && !pmi_valid(shift_q) |=> !sda_oe_q ##1 !sda_oe_q;
    endproperty
    a_reg_nack: assert property (p_reg_nack) // RULE_09
        else $error("invalid register address acknowledged");
    property p_ack_hold;
        ackph_q && sda_oe_q && state_q != ST_RDATA && !scl_fall && !start_ev
            && !stop_ev |=> sda_oe_q;
    endproperty
    a_ack_hold: assert property (p_ack_hold) // RULE_17
        else $error("acknowledge dropped inside its slot");
    property p_ptr_step;
        s_wdata_slot |=> ptr_q == (($past(ptr_q) == PMI_ZERO_OFS) ?
            PMI_ZERO_OFS : 8'($past(ptr_q) + 8'h01));
    endproperty
    a_ptr_step: assert property (p_ptr_step) // RULE_11
        else $error("pointer step wrong after write");
    property p_write_store;
        s_wdata_slot ##0 pmi_writable(ptr_q)
            |=> mem_q[$past(ptr_q[4:0])] == $past(shift_q) && sda_oe_q;
    endproperty
    a_write_store: assert property (p_write_store) // RULE_12
        else $error("data byte not stored and acknowledged");
    property p_msb_first;
        s_rd_enter |=> sda_oe_q == !tx_q[7] && state_q == ST_RDATA;
    endproperty
    a_msb_first: assert property (p_msb_first) // RULE_14
        else $error("read byte not started at top bit");
    property p_nack_release;
        scl_rise && state_q == ST_RDATA && ackph_q && sync.sda_s && !start_ev
            && !stop_ev |=> !sda_oe_q && state_q == ST_IDLE;
    endproperty
    a_nack_release: assert property (p_nack_release) // RULE_16
        else $error("line not released after host refusal");
    property p_soft_default;
        soft_rst |=> undervoltage_lockout_config == PMI_REG_RST
            && power_config == PMI_REG_RST;
    endproperty
    a_soft_default: assert property (p_soft_default) // RULE_21
        else $error("soft reset left register changed");
endmodule : pmi_i2c_regs

// ==== pkg/pmi_pkg.sv ====
// Constants, types and helpers of the register access target
// Behaviour
// [RULE_01] Serial clock up to 400 kHz supported
// [RULE_02] Host sends target address first after START
// [RULE_03] Direction bit high reads, low writes
// [RULE_04] Host sends register address after address byte
// [RULE_05] Data sampled on serial clock rising edge
// [RULE_06] Data change while clock high is control
// [RULE_07] Idle bus: both lines released high
// [RULE_08] Acknowledge own target address, either direction
// [RULE_09] Acknowledge valid register address, else refuse
// [RULE_10] Single write: store, acknowledge, then STOP
// [RULE_11] Pointer advances per byte, holds at zero
// [RULE_12] Burst write: acknowledge every data byte
// [RULE_13] Read needs address write, repeated START
// [RULE_14] Send selected register, most significant first
// [RULE_15] Host acknowledge requests next register byte
// [RULE_16] Host refusal ends read; release data line
// [RULE_17] Acknowledge low through ninth clock high
// [RULE_18] Refusal leaves data high through ninth clock
// [RULE_19] Host ends with STOP or repeated START
// [RULE_20] Target address fixed upper six, strap lsb
// [RULE_21] Hard or soft reset restores register defaults
// [RULE_22] Read pointer advances like writes, zero holds
// [RULE_23] Lines synchronised; edges, conditions from them
package pmi_pkg;

    localparam int          PMI_REGS       = 32;
    localparam logic [5:0]  PMI_ADDR_HI    = 6'h15;
    localparam logic [7:0]  PMI_ZERO_OFS   = 8'h00;
    localparam logic [7:0]  PMI_UVLO_OFS   = 8'h1e;
    localparam logic [7:0]  PMI_PWR_OFS    = 8'h1f;
    localparam logic [3:0]  PMI_ACK_SLOT   = 4'h8;
    localparam logic [31:0] PMI_VALID_MASK = 32'hfe03fffb;
    localparam logic [31:0] PMI_RO_MASK    = 32'h00038003;
    // Identity byte at offset zero; value arbitrary
    localparam logic [7:0]  PMI_CHIP_ID    = 8'h5a;
    localparam logic [7:0]  PMI_REG_RST    = 8'h00;
    localparam logic [7:0]  PMI_READ_NONE  = 8'h00;

    // Serial clock bound and the shortest half period it allows
    localparam int PMI_SCL_MAX_KHZ = 400;
    localparam int PMI_SYS_KHZ     = 25000;
    localparam int PMI_HALF_CYC    = PMI_SYS_KHZ / (2 * PMI_SCL_MAX_KHZ);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_REG   = 3'h2,
        ST_WDATA = 3'h3,
        ST_RDATA = 3'h4
    } pmi_state_t;

    function automatic logic pmi_valid(input logic [7:0] ofs);
        pmi_valid = (ofs[7:5] == 3'h0) && PMI_VALID_MASK[ofs[4:0]];
    endfunction : pmi_valid

    function automatic logic pmi_writable(input logic [7:0] ofs);
        pmi_writable = pmi_valid(ofs) && !PMI_RO_MASK[ofs[4:0]];
    endfunction : pmi_writable

    function automatic logic [7:0] pmi_next_ptr(input logic [7:0] ofs);
        pmi_next_ptr = (ofs == PMI_ZERO_OFS) ? ofs : 8'(ofs + 8'h01);
    endfunction : pmi_next_ptr

    function automatic logic [7:0] pmi_reg_default(input logic [4:0] idx);
        pmi_reg_default = (idx == PMI_ZERO_OFS[4:0]) ? PMI_CHIP_ID
                                                      : PMI_REG_RST;
    endfunction : pmi_reg_default

endpackage : pmi_pkg

// ==== pkg/pmi_sync_if.sv ====
// Synchronised bus lines and strap handed to the protocol engine
`timescale 1ns/100ps
interface pmi_sync_if;
    logic scl_s;
    logic sda_s;
    logic sel_s;

    modport src (output scl_s, output sda_s, output sel_s);
    modport dst (input  scl_s, input  sda_s, input  sel_s);
endinterface : pmi_sync_if

// ==== src/pmi_pin_sync.sv ====
// Two-flop synchronisers for the serial lines and address strap
`timescale 1ns/100ps
module pmi_pin_sync (
    // Clock and reset
    input  wire logic   sys_clk,
    input  wire logic   resetn,
    // Pins
    input  wire logic   scl_i,
    input  wire logic   sda_i,
    input  wire logic   otp_addr_sel,
    // Synchronised side
    pmi_sync_if.src     sync
);
    logic [2:0] meta_q;
    logic [2:0] meta_d;
    logic [2:0] line_q;
    logic [2:0] line_d;

    // Lines rest high, so the clock and data bits reset high; the strap bit resets low
    always_comb
    begin
        meta_d = {otp_addr_sel, sda_i, scl_i}; // RULE_23
        line_d = meta_q;                       // RULE_01
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= 3'h3;
            line_q <= 3'h3;
        end
        else
        begin
            meta_q <= meta_d;
            line_q <= line_d;
        end
    end

    assign sync.scl_s = line_q[0];
    assign sync.sda_s = line_q[1];
    assign sync.sel_s = line_q[2];

endmodule : pmi_pin_sync

// ==== test/pmi_host_model.sv ====
// Behavioural two-wire bus host that drives the target and reports results
`timescale 1ns/100ps
module pmi_host_model (
    // Link clock
    input  wire logic       link_clk,
    // Bus lines, released means high
    output logic            scl,
    output logic            sda_drv,
    input  wire logic       sda,
    // Observed results
    output logic            obs_stb,
    output logic [8:0]      obs_val
);
    int half = 10;

    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
        obs_stb = 1'b0;
        obs_val = 9'h000;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask : tick

    // Never faster than 400 kHz
    task automatic set_half(input int h);
        half = (h < 10) ? 10 : h;
    endtask : set_half

    // Start or repeated start; clock then stands low
    task automatic start();
        sda_drv = 1'b1;
        tick(half / 2);
        scl = 1'b1;
        tick(half);
        sda_drv = 1'b0;
        tick(half);
        scl = 1'b0;
    endtask : start

    task automatic stop();
        tick(half / 2);
        sda_drv = 1'b0;
        tick(half - half / 2);
        scl = 1'b1;
        tick(half);
        sda_drv = 1'b1;
        tick(half);
    endtask : stop

    // Data set mid-low, held through high; line sampled early and late
    task automatic bit_x(input logic b, output logic r, output logic f);
        tick(half / 2);
        sda_drv = b;
        tick(half - half / 2);
        scl = 1'b1;
        tick(2);
        r = sda;
        tick(half - 4);
        f = sda;
        tick(2);
        scl = 1'b0;
    endtask : bit_x

    task automatic report(input logic [8:0] v);
        obs_val = v;
        obs_stb = 1'b1;
        tick(1);
        obs_stb = 1'b0;
    endtask : report

    task automatic bits(input logic [7:0] tx, input int n);
        logic r, f;
        for (int i = 7; i > 7 - n; i--)
            bit_x(tx[i], r, f);
    endtask : bits

    // Byte out, then acknowledge slot left released
    task automatic wr(input logic [7:0] tx);
        logic r, f;
        bits(tx, 8);
        bit_x(1'b1, r, f);
        report({7'h00, r, f});
    endtask : wr

    // Byte in; host acknowledges unless last
    task automatic rd(input logic last);
        logic       r, f, bad;
        logic [7:0] v;
        bad = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'b1, r, f);
            v[i] = r;
            bad = bad | (r !== f);
        end
        bit_x(last, r, f);
        report({bad, v});
    endtask : rd
endmodule : pmi_host_model

// ==== test/testbench.sv ====
// Self-checking bench for the register access target
`timescale 1ns/100ps
module testbench;
    import pmi_pkg::*;
    logic       sys_clk, link_clk, resetn, soft_rst, otp_addr_sel;
    logic       scl, sda_drv, sda_o, sda_oe, obs_stb;
    logic [8:0] obs_val, exp_q [$];
    logic [7:0] uvlo, pwr, a, b;
    logic [7:0] bad_ofs [3] = '{8'h02, 8'h12, 8'h20};
    string      nam_q [$];
    int         n_errors = 0;
    int         compares = 0;
    wire        sda_line = sda_drv & ~(sda_oe & ~sda_o);

    pmi_i2c_regs pmi_i2c_regs_inst (
        .sys_clk(sys_clk), .resetn(resetn), .soft_rst(soft_rst),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .otp_addr_sel(otp_addr_sel),
        .undervoltage_lockout_config(uvlo), .power_config(pwr));

    pmi_host_model host_inst (
        .link_clk(link_clk), .scl(scl), .sda_drv(sda_drv), .sda(sda_line),
        .obs_stb(obs_stb), .obs_val(obs_val));

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #62.5 link_clk = ~link_clk;
    end

    task automatic report_and_stop();
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input string nm, input logic [8:0] e,
                         input logic [8:0] s);
        compares++;
        if (s !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic note(input string nm, input logic [8:0] e);
        nam_q.push_back(nm);
        exp_q.push_back(e);
    endtask : note

    task automatic send(input logic [7:0] v, input logic ack);
        note("ack", ack ? 9'h000 : 9'h003);
        host_inst.wr(v);
    endtask : send

    task automatic write_seq(input logic [7:0] r, input logic [7:0] d [2],
                             input int n);
        host_inst.start();
        send({PMI_ADDR_HI, otp_addr_sel, 1'b0}, 1'b1);
        send(r, 1'b1);
        for (int i = 0; i < n; i++)
            send(d[i], 1'b1);
        host_inst.stop();
    endtask : write_seq

    task automatic read_seq(input logic [7:0] r, input logic [7:0] e [2],
                            input int n);
        host_inst.start();
        send({PMI_ADDR_HI, otp_addr_sel, 1'b0}, 1'b1);
        send(r, 1'b1);
        host_inst.start();
        send({PMI_ADDR_HI, otp_addr_sel, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            note("read", {1'b0, e[i]});
            host_inst.rd(i == n - 1);
        end
        host_inst.stop();
        check("sda_oe", 9'h000, {8'h00, sda_oe});
    endtask : read_seq

    task automatic sys_wait(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : sys_wait

    // Results are matched against notes in the order they were made
    always @(posedge link_clk)
        if (obs_stb === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("spare", 9'h1ff, obs_val);
            else
                check(nam_q.pop_front(), exp_q.pop_front(),
                      obs_val);
        end

    initial
    begin
        #4_000_000;
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        resetn = 1'b0;
        soft_rst = 1'b0;
        otp_addr_sel = 1'b0;
        void'($urandom(32'h816a7671));
        sys_wait(4);
        resetn = 1'b1;
        sys_wait(4);
        check("uvlo", 9'h000, {1'b0, uvlo});
        check("pwr", 9'h000, {1'b0, pwr});
        read_seq(PMI_ZERO_OFS, '{PMI_CHIP_ID, PMI_CHIP_ID}, 2);
        for (int s = 0; s < 2; s++)
        begin
            a = 8'($urandom);
            b = 8'($urandom);
            host_inst.set_half(10 + s * 8 + int'($urandom_range(0, 4)));
            otp_addr_sel = s[0];
            sys_wait(4);
            write_seq(PMI_UVLO_OFS, '{a, b}, 2);
            check("uvlo", {1'b0, a}, {1'b0, uvlo});
            check("pwr", {1'b0, b}, {1'b0, pwr});
            read_seq(PMI_UVLO_OFS, '{a, b}, 2);
            host_inst.start();
            send({PMI_ADDR_HI, ~otp_addr_sel, 1'b0}, 1'b0);
            host_inst.stop();
        end
        foreach (bad_ofs[i])
        begin
            host_inst.start();
            send({PMI_ADDR_HI, otp_addr_sel, 1'b0}, 1'b1);
            send(bad_ofs[i], 1'b0);
            host_inst.stop();
        end
        // Partial byte cut short by a stop must not land
        host_inst.start();
        send({PMI_ADDR_HI, otp_addr_sel, 1'b0}, 1'b1);
        send(PMI_PWR_OFS, 1'b1);
        host_inst.bits(~b, 4);
        host_inst.stop();
        check("pwr", {1'b0, b}, {1'b0, pwr});
        write_seq(PMI_ZERO_OFS, '{a, b}, 2);
        read_seq(PMI_ZERO_OFS, '{PMI_CHIP_ID, PMI_CHIP_ID}, 2);
        soft_rst = 1'b1;
        sys_wait(1);
        soft_rst = 1'b0;
        sys_wait(1);
        check("uvlo", 9'h000, {1'b0, uvlo});
        check("pwr", 9'h000, {1'b0, pwr});
        write_seq(PMI_PWR_OFS, '{a, b}, 1);
        check("pwr", {1'b0, a}, {1'b0, pwr});
        read_seq(PMI_PWR_OFS, '{a, PMI_READ_NONE}, 2);
        resetn = 1'b0;
        sys_wait(2);
        resetn = 1'b1;
        sys_wait(4);
        check("pwr", 9'h000, {1'b0, pwr});
        read_seq(PMI_PWR_OFS, '{8'h00, 8'h00}, 1);
        repeat (4) @(posedge link_clk);
        check("pending", 9'h000, 9'(exp_q.size()));
        report_and_stop();
    end
endmodule : testbench
